// File: bench/tcv_top_tb.sv
`default_nettype none

`include "tcv_regs.svh"

module tcv_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;       // 125 MHz
  logic        resetn  = 1'b0;       // Active low reset
  logic [15:0] count   = 16'h0000;   // Counter fed to the block
  logic [5:0]  pin     = 6'h00;      // Capture pins
  logic        wcyc, wstb, wwe, ack;
  logic [9:0]  wadr;
  logic [3:0]  wsel;
  logic [31:0] wdo, wdi;
  logic [5:0]  flag, match;
  int          bad_count   = 0;
  int          checks_done = 0;
  int          cyc_n       = 0;      // Cycles since start, for the hang guard
  int          mch         = 1;      // Channel whose match pulses are counted
  int          mcnt        = 0;      // Match pulses seen on that channel
  logic [7:0]  q;

  always #4 sys_clk = ~sys_clk;

  tcv_wb_master mst_u (.sys_clk(sys_clk), .wb_ack_i(ack), .wb_dat_i(wdi), .wb_cyc_o(wcyc),
    .wb_stb_o(wstb), .wb_we_o(wwe), .wb_adr_o(wadr), .wb_sel_o(wsel), .wb_dat_o(wdo));

  tcv_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wcyc), .wb_stb_i(wstb),
    .wb_we_i(wwe), .wb_adr_i(wadr), .wb_sel_i(wsel), .wb_dat_i(wdo), .wb_dat_o(wdi),
    .wb_ack_o(ack), .timer_count(count), .capture_pin(pin),
    .channel_event_flag(flag), .compare_match(match));

  // Pulse counter; tasks take differences so only this block writes it
  always @(posedge sys_clk) begin
    if (match[mch] === 1'b1) mcnt <= mcnt + 1;
    cyc_n <= cyc_n + 1;
    // Hang guard, far above the few hundred cycles the run needs
    if (cyc_n == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [6:0] hi_idx(input int ch);
    return 7'(`TCV_CH0_HI_IDX + 3 * ch);
  endfunction : hi_idx

  task automatic set_ctl(input int ch, input logic [3:0] ctl);
    mst_u.wr(7'(`TCV_CTRL_BASE_IDX + ch), {4'h0, ctl});
  endtask : set_ctl

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_clk

  // Byte halves of every channel, plus an unmapped read
  task automatic t_bytes();
    for (int ch = 0; ch < 6; ch++) begin
      mst_u.wr(hi_idx(ch), 8'ha0 + 8'(ch));
      mst_u.wr(hi_idx(ch) + 7'h01, 8'h50 + 8'(ch));
    end
    for (int ch = 0; ch < 6; ch++) begin
      mst_u.rd(hi_idx(ch), q);
      check("value high", {8'h00, q}, {8'h00, 8'ha0 + 8'(ch)});
      mst_u.rd(hi_idx(ch) + 7'h01, q);
      check("value low", {8'h00, q}, {8'h00, 8'h50 + 8'(ch)});
    end
    mst_u.rd(7'h10, q);
    check("unmapped read", {8'h00, q}, 16'h0000);
  endtask : t_bytes

  // Rising edge on channel 0 pin, counter held so the latch is known
  task automatic edge0(input logic [15:0] val);
    @(posedge sys_clk);
    count  <= val;
    pin[0] <= 1'b0;
    wait_clk(4);
    pin[0] <= 1'b1;
    wait_clk(8);
  endtask : edge0

  // Capture, then a capture held off between high and low reads
  task automatic t_capture();
    set_ctl(0, 4'h1);
    edge0(16'hbeef);
    check("capture flag", {15'h0, flag[0]}, 16'h0001);
    mst_u.wr(`TCV_FLAGS_IDX, 8'h3f);
    wait_clk(1);
    check("flag cleared", {15'h0, flag[0]}, 16'h0000);
    mst_u.rd(hi_idx(0), q);
    check("capture high", {8'h00, q}, 16'h00be);
    edge0(16'h1234);
    mst_u.rd(hi_idx(0) + 7'h01, q);
    check("held low", {8'h00, q}, 16'h00ef);
    edge0(16'h1234);
    mst_u.rd(hi_idx(0), q);
    check("new high", {8'h00, q}, 16'h0012);
    mst_u.rd(hi_idx(0) + 7'h01, q);
    check("new low", {8'h00, q}, 16'h0034);
  endtask : t_capture

  // Falling-edge capture on channel 3; a rise must be ignored
  task automatic t_falling();
    set_ctl(3, 4'h2);
    mst_u.rd(7'(`TCV_CTRL_BASE_IDX + 3), q);
    check("ctl readback", {8'h00, q}, 16'h0002);
    @(posedge sys_clk);
    count  <= 16'hc3a5;
    pin[3] <= 1'b1;
    wait_clk(8);
    check("no rise capture", {15'h0, flag[3]}, 16'h0000);
    pin[3] <= 1'b0;
    wait_clk(8);
    check("fall flag", {15'h0, flag[3]}, 16'h0001);
    mst_u.rd(hi_idx(3), q);
    check("fall high", {8'h00, q}, 16'h00c3);
    mst_u.rd(hi_idx(3) + 7'h01, q);
    check("fall low", {8'h00, q}, 16'h00a5);
  endtask : t_falling

  // Compare on one channel, then matches suppressed after a lone high write
  task automatic t_compare(input int ch, input logic [3:0] ctl);
    int m0;
    mch = ch;
    @(posedge sys_clk);
    count <= 16'h0000;
    set_ctl(ch, ctl);
    mst_u.wr(hi_idx(ch), 8'h12);
    mst_u.wr(hi_idx(ch) + 7'h01, 8'h34);
    m0 = mcnt;
    count <= 16'h1234;
    wait_clk(4);
    check("match count", 16'(mcnt - m0), 16'h0001);
    check("compare flag", {15'h0, flag[ch]}, 16'h0001);
    count <= 16'h0000;
    mst_u.wr(hi_idx(ch), 8'h56);
    m0 = mcnt;
    count <= 16'h5634;
    wait_clk(4);
    check("blocked match", 16'(mcnt - m0), 16'h0000);
    count <= 16'h0000;
    mst_u.wr(hi_idx(ch) + 7'h01, 8'h78);
    m0 = mcnt;
    count <= 16'h5678;
    wait_clk(4);
    check("match after low", 16'(mcnt - m0), 16'h0001);
  endtask : t_compare

  task automatic wrap_up();
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    wait_clk(16);
    resetn <= 1'b1;
    t_bytes();
    t_capture();
    t_falling();
    t_compare(1, 4'h5);
    t_compare(2, 4'h9);
    wrap_up();
  end
endmodule : tcv_top_tb

`default_nettype wire

// File: bench/tcv_wb_master.sv
`default_nettype none

// Processor side of the register bus: one classic Wishbone cycle per call
module tcv_wb_master (
  input  wire logic        sys_clk,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic      [9:0]  wb_adr_o,
  output logic      [3:0]  wb_sel_o,
  output logic      [31:0] wb_dat_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 10'h000;
    wb_sel_o = 4'hf;
    wb_dat_o = 32'h0000_0000;
  end

  // One cycle; holds everything until ack is seen at a rising edge
  task automatic xfer(input logic we, input logic [6:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge sys_clk);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= {1'b0, idx, 2'b00};
    wb_dat_o <= {24'h00_0000, d};
    do @(posedge sys_clk); while (wb_ack_i !== 1'b1);
    q = wb_dat_i[7:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // Stale write data is not left looking valid
    wb_dat_o <= ~wb_dat_o;
  endtask : xfer

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [6:0] idx, output logic [7:0] q);
    xfer(1'b0, idx, 8'h00, q);
  endtask : rd
endmodule : tcv_wb_master

`default_nettype wire

// File: inc/tcv_pkg.sv
`default_nettype none

`include "tcv_regs.svh"

package tcv_pkg;

  // Operating mode of one channel
  typedef enum logic [1:0] {
    TCV_PORT        = 2'b00,  // Edge select zero, pin left to the port
    TCV_CAPTURE     = 2'b01,  // Input capture
    TCV_COMPARE     = 2'b10,  // Unbuffered output compare or PWM
    TCV_BUF_COMPARE = 2'b11   // Buffered output compare or PWM
  } tcv_mode_t;

  // Decode a control word into the channel mode
  function automatic tcv_mode_t tcv_mode(input logic [3:0] ctl);
    tcv_mode_t m;
    m = TCV_PORT;
    if (ctl[`TCV_CTL_ELS_HI_BIT:`TCV_CTL_ELS_LO_BIT] == 2'h0) begin
      m = TCV_PORT;
    end else if (ctl[`TCV_CTL_BUF_SEL_BIT]) begin
      m = TCV_BUF_COMPARE;
    end else if (ctl[`TCV_CTL_MODE_SEL_BIT]) begin
      m = TCV_COMPARE;
    end else begin
      m = TCV_CAPTURE;
    end
    return m;
  endfunction : tcv_mode

endpackage : tcv_pkg

`default_nettype wire

// File: inc/tcv_regs.svh
`ifndef TCV_REGS_SVH
`define TCV_REGS_SVH

// Register indices; the Wishbone byte address is four times the index
`define TCV_CH0_HI_IDX 7'h27
`define TCV_CH0_LO_IDX 7'h28
`define TCV_CH1_HI_IDX 7'h2a
`define TCV_CH1_LO_IDX 7'h2b
`define TCV_CH2_HI_IDX 7'h2d
`define TCV_CH2_LO_IDX 7'h2e
`define TCV_CH3_HI_IDX 7'h30
`define TCV_CH3_LO_IDX 7'h31
`define TCV_CH4_HI_IDX 7'h33
`define TCV_CH4_LO_IDX 7'h34
`define TCV_CH5_HI_IDX 7'h36
`define TCV_CH5_LO_IDX 7'h37

// Channel mode control words, one per channel from this index upward
`define TCV_CTRL_BASE_IDX 7'h40
// Channel event flags, write one to clear
`define TCV_FLAGS_IDX 7'h48

// Reset values
`define TCV_CTRL_RESET 4'h0
`define TCV_FLAGS_RESET 6'h00

// Field positions inside a channel control word
`define TCV_CTL_ELS_LO_BIT 0
`define TCV_CTL_ELS_HI_BIT 1
`define TCV_CTL_MODE_SEL_BIT 2
`define TCV_CTL_BUF_SEL_BIT 3

`endif

// File: logic/tcv_chan.sv
`default_nettype none

`include "tcv_regs.svh"

module tcv_chan (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  ctl,
  input  wire logic [15:0] count,
  input  wire logic        pin_s,
  input  wire logic        wr_hi,
  input  wire logic        wr_lo,
  input  wire logic        rd_hi,
  input  wire logic        rd_lo,
  input  wire logic [7:0]  wdat,
  input  wire logic        flag_clr,
  output logic      [15:0] value_q,
  output logic             flag_q,
  output logic             match_q,
  output logic             cap_blk_q,
  output logic             cmp_blk_q
);

  tcv_pkg::tcv_mode_t mode;       // Decoded channel mode
  logic               ms_zero;    // Both mode select bits clear
  logic               pin_prev_q; // Pin level one cycle ago
  logic               eq_prev_q;  // Equality one cycle ago
  logic               edge_hit;   // Active edge seen on the pin
  logic               eq;         // Counter equals channel value
  logic               cap_evt;    // Capture takes place this cycle
  logic               cmp_evt;    // Compare match this cycle

  assign mode    = tcv_pkg::tcv_mode(ctl);
  assign ms_zero = !ctl[`TCV_CTL_BUF_SEL_BIT] && !ctl[`TCV_CTL_MODE_SEL_BIT];
  // Edge select low bit picks rising, high bit falling
  assign edge_hit = (ctl[`TCV_CTL_ELS_LO_BIT] && pin_s && !pin_prev_q) ||
                    (ctl[`TCV_CTL_ELS_HI_BIT] && !pin_s && pin_prev_q);
  assign cap_evt  = (mode == tcv_pkg::TCV_CAPTURE) && edge_hit && !cap_blk_q;
  assign eq       = (count == value_q);
  // Only the first cycle of equality counts, the counter may dwell
  assign cmp_evt  = ((mode == tcv_pkg::TCV_COMPARE) || (mode == tcv_pkg::TCV_BUF_COMPARE))
                    && eq && !eq_prev_q && !cmp_blk_q;

  // Value register, deliberately without reset
  always_ff @(posedge sys_clk) begin
    if (cap_evt) begin
      value_q <= count;
    end
    // Software write lands after a same-cycle capture and wins
    if (wr_hi) begin
      value_q[15:8] <= wdat;
    end
    if (wr_lo) begin
      value_q[7:0] <= wdat;
    end
  end

  // History for edge and equality detection
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_prev_q <= 1'b0;
      eq_prev_q  <= 1'b0;
    end else begin
      pin_prev_q <= pin_s;
      eq_prev_q  <= eq;
    end
  end

  // Capture interlock: high read holds, low read releases
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cap_blk_q <= 1'b0;
    end else if (rd_lo) begin
      cap_blk_q <= 1'b0;
    end else if (rd_hi && ms_zero) begin
      cap_blk_q <= 1'b1;
    end
  end

  // Compare interlock: high write holds, low write releases
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmp_blk_q <= 1'b0;
    end else if (wr_lo) begin
      cmp_blk_q <= 1'b0;
    end else if (wr_hi && !ms_zero) begin
      cmp_blk_q <= 1'b1;
    end
  end

  // Event flag, a new event beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flag_q  <= 1'b0;
      match_q <= 1'b0;
    end else begin
      flag_q  <= (flag_q && !flag_clr) || cap_evt || cmp_evt;
      match_q <= cmp_evt;
    end
  end

  a_capture_loads: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cap_evt && !wr_hi && !wr_lo) |=> (value_q == $past(count)))
    else $error("capture did not load counter");

  a_capture_held: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cap_blk_q && !wr_hi && !wr_lo) |=> (value_q == $past(value_q)))
    else $error("value changed while capture blocked");

  a_compare_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmp_blk_q |=> !match_q)
    else $error("match while compare blocked");

  a_match_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
    ($rose(eq) && !ms_zero && !cmp_blk_q && (mode != tcv_pkg::TCV_PORT))
      |=> (match_q && flag_q))
    else $error("match did not set flag");

endmodule : tcv_chan

`default_nettype wire

// File: logic/tcv_top.sv
// Behaviour
// - Capture latches counter into channel value
// - Compare mode matches counter against written value
// - Value registers have no reset value
// - High read in capture mode blocks captures
// - High write in compare mode blocks matches
// - Flag set by capture edge or match
// - Mode bits 00 capture, 01/1X compare, once an edge select bit is set (edge select 00 is port)
`default_nettype none

`include "tcv_regs.svh"

module tcv_top #(
  parameter int NCH   = 6,  // Number of channels
  parameter int ADR_W = 10  // Wishbone byte address width
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // Wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Timer side
  input  wire logic [15:0]      timer_count,
  input  wire logic [NCH-1:0]   capture_pin,
  output logic      [NCH-1:0]   channel_event_flag,
  output logic      [NCH-1:0]   compare_match
);

  // Register index of each high and low value byte
  localparam logic [6:0] HI_IDX [6] = '{
    `TCV_CH0_HI_IDX, `TCV_CH1_HI_IDX, `TCV_CH2_HI_IDX,
    `TCV_CH3_HI_IDX, `TCV_CH4_HI_IDX, `TCV_CH5_HI_IDX
  };
  localparam logic [6:0] LO_IDX [6] = '{
    `TCV_CH0_LO_IDX, `TCV_CH1_LO_IDX, `TCV_CH2_LO_IDX,
    `TCV_CH3_LO_IDX, `TCV_CH4_LO_IDX, `TCV_CH5_LO_IDX
  };

  // Register map, by word index (byte address is four times this)
  //   Value bytes, one high and one low per channel, three apart
  //   Control word per channel from the control base upward
  //   One status word holding flags and both interlock vectors
  // Status word layout
  //   Bits 5:0   event flags, write one to clear
  //   Bits 13:8  capture interlock per channel, read only
  //   Bits 21:16 compare interlock per channel, read only
  // Control word layout
  //   Bit 0 rising edge enable, bit 1 falling edge enable
  //   Bit 2 plain compare select, bit 3 buffered compare select
  // Hazards software must keep in mind
  //   A lone high read in capture mode freezes the channel
  //   until the matching low read; nothing times it out
  //   A lone high write in compare mode silences matches
  //   until the matching low write; equality seen meanwhile is lost
  //   Value bytes are undefined until written or captured
  // Only the low byte lane carries write data; wider write lanes are ignored,
  // which keeps the map byte-oriented like the original part

  // Bus handshake
  logic               ack_q;        // Acknowledge, one cycle
  logic [31:0]        dat_q;        // Registered read data
  logic               acc;          // Request taken this edge
  logic               acc_wr;       // Write with the low lane enabled
  logic               acc_rd;       // Read request
  logic [6:0]         idx;          // Register index of request

  // Register file
  logic [3:0]         ctl_q [NCH];  // Mode control word per channel
  logic [31:0]        rdata_d;      // Read mux output
  logic               hit_d;        // Index maps to a register

  // Pin synchroniser
  logic [NCH-1:0]     pin_meta_q;   // First stage, read only by stage two
  logic [NCH-1:0]     pin_sync_q;   // Second stage, safe to use

  // Per-channel strobes and state
  logic [NCH-1:0]     wr_hi;
  logic [NCH-1:0]     wr_lo;
  logic [NCH-1:0]     rd_hi;
  logic [NCH-1:0]     rd_lo;
  logic [NCH-1:0]     flag_clr;
  logic [NCH-1:0]     cap_blk;
  logic [NCH-1:0]     cmp_blk;
  logic [15:0]        value [NCH];

  // True when the index addresses a given register
  function automatic logic idx_is(input logic [6:0] a, input logic [6:0] b);
    return a == b;
  endfunction : idx_is

  // A request is taken only while no acknowledge is out,
  // so each access has exactly one side effect
  assign acc    = wb_cyc_i && wb_stb_i && !ack_q;
  assign acc_wr = acc && wb_we_i && wb_sel_i[0];
  assign acc_rd = acc && !wb_we_i;
  assign idx    = wb_adr_i[8:2];

  // Acknowledge one cycle after the request, dropped the next
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  // Read data captured with the acknowledge, zero otherwise
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dat_q <= 32'h0000_0000;
    end else if (acc_rd) begin
      dat_q <= rdata_d;
    end else begin
      dat_q <= 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Two-stage synchroniser for the capture pins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= capture_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Strobe decode for the value bytes and flag clears
  always_comb begin
    wr_hi    = '0;
    wr_lo    = '0;
    rd_hi    = '0;
    rd_lo    = '0;
    flag_clr = '0;
    for (int c = 0; c < NCH; c++) begin
      wr_hi[c] = acc_wr && idx_is(idx, HI_IDX[c]);
      wr_lo[c] = acc_wr && idx_is(idx, LO_IDX[c]);
      rd_hi[c] = acc_rd && idx_is(idx, HI_IDX[c]);
      rd_lo[c] = acc_rd && idx_is(idx, LO_IDX[c]);
      // Write one to clear a flag
      flag_clr[c] = acc_wr && idx_is(idx, `TCV_FLAGS_IDX) && wb_dat_i[c];
    end
  end

  // Channel mode control words, software steers each channel
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int c = 0; c < NCH; c++) begin
        ctl_q[c] <= `TCV_CTRL_RESET;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (acc_wr && idx_is(idx, `TCV_CTRL_BASE_IDX + 7'(c))) begin
          ctl_q[c] <= wb_dat_i[3:0];
        end
      end
    end
  end

  // Read mux; unmapped indices read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      if (idx_is(idx, HI_IDX[c])) begin
        rdata_d = {24'h00_0000, value[c][15:8]};
        hit_d   = 1'b1;
      end
      if (idx_is(idx, LO_IDX[c])) begin
        rdata_d = {24'h00_0000, value[c][7:0]};
        hit_d   = 1'b1;
      end
      if (idx_is(idx, `TCV_CTRL_BASE_IDX + 7'(c))) begin
        rdata_d = {28'h000_0000, ctl_q[c]};
        hit_d   = 1'b1;
      end
    end
    // Flags and interlock state for software to inspect
    if (idx_is(idx, `TCV_FLAGS_IDX)) begin
      rdata_d = {8'h00, 2'h0, cmp_blk, 2'h0, cap_blk, 2'h0, channel_event_flag};
      hit_d   = 1'b1;
    end
  end

  // One channel engine per channel
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    tcv_chan u_chan (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .ctl       (ctl_q[g]),
      .count     (timer_count),
      .pin_s     (pin_sync_q[g]),
      .wr_hi     (wr_hi[g]),
      .wr_lo     (wr_lo[g]),
      .rd_hi     (rd_hi[g]),
      .rd_lo     (rd_lo[g]),
      .wdat      (wb_dat_i[7:0]),
      .flag_clr  (flag_clr[g]),
      .value_q   (value[g]),
      .flag_q    (channel_event_flag[g]),
      .match_q   (compare_match[g]),
      .cap_blk_q (cap_blk[g]),
      .cmp_blk_q (cmp_blk[g])
    );
  end

  // Bus checks

  a_ack_single: assert property (@(posedge sys_clk) disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged next cycle");

  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    (acc_rd && !hit_d) |=> (wb_ack_o && wb_dat_o == 32'h0000_0000))
    else $error("unmapped read returned nonzero");

  // Channel checks across the bus

  a_split_high: assert property (@(posedge sys_clk) disable iff (!resetn)
    (acc_rd && idx_is(idx, HI_IDX[0]))
      |=> (wb_dat_o == {24'h00_0000, $past(value[0][15:8])}))
    else $error("high byte read mismatch");

  a_split_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    (acc_rd && idx_is(idx, LO_IDX[0]))
      |=> (wb_dat_o == {24'h00_0000, $past(value[0][7:0])}))
    else $error("low byte read mismatch");

  a_hi_read_blocks: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rd_hi[0] && ctl_q[0][3:2] == 2'b00) |=> cap_blk[0] [*2])
    else $error("high read did not block capture");

  a_hi_write_blocks: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wr_hi[0] && ctl_q[0][3:2] != 2'b00) |=> cmp_blk[0])
    else $error("high write did not block compare");

  a_mode_capture: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ctl_q[0][3:2] != 2'b00) |-> (tcv_pkg::tcv_mode(ctl_q[0]) != tcv_pkg::TCV_CAPTURE))
    else $error("compare bits decoded as capture");

  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
    (channel_event_flag[0] && !flag_clr[0]) |=> channel_event_flag[0])
    else $error("flag dropped without clear");

  // Read data must be quiet outside the acknowledge cycle,
  // so a master that samples late never sees a stale byte
  a_dat_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data not zero without ack");

  // Per-channel checks, repeated so every channel is watched
  for (genvar g = 0; g < NCH; g++) begin : g_chk

    // Low read always releases the capture hold
    a_lo_read_frees: assert property (@(posedge sys_clk) disable iff (!resetn)
      rd_lo[g] |=> !cap_blk[g])
      else $error("low read left capture blocked");

    // Low write always releases the compare hold
    a_lo_write_frees: assert property (@(posedge sys_clk) disable iff (!resetn)
      wr_lo[g] |=> !cmp_blk[g])
      else $error("low write left compare blocked");

    // High byte write lands in bits 15:8
    a_wr_high_lands: assert property (@(posedge sys_clk) disable iff (!resetn)
      wr_hi[g] |=> (value[g][15:8] == $past(wb_dat_i[7:0])))
      else $error("high byte write lost");

    // Low byte write lands in bits 7:0
    a_wr_low_lands: assert property (@(posedge sys_clk) disable iff (!resetn)
      wr_lo[g] |=> (value[g][7:0] == $past(wb_dat_i[7:0])))
      else $error("low byte write lost");

    // Control write reaches the channel mode word
    a_ctl_lands: assert property (@(posedge sys_clk) disable iff (!resetn)
      (acc_wr && idx_is(idx, `TCV_CTRL_BASE_IDX + 7'(g)))
        |=> (ctl_q[g] == $past(wb_dat_i[3:0])))
      else $error("control write lost");

    // A dwelling counter must not give a second match
    a_match_single: assert property (@(posedge sys_clk) disable iff (!resetn)
      compare_match[g] |=> !compare_match[g])
      else $error("match pulse longer than one cycle");

    // Every match pulse is mirrored in the sticky flag
    a_match_flagged: assert property (@(posedge sys_clk) disable iff (!resetn)
      compare_match[g] |-> channel_event_flag[g])
      else $error("match without flag");

  end

endmodule : tcv_top

`default_nettype wire
